/* rtl/dcn_consts.svh */
// Constants for the daisy-chain frame node: header fields, codes, offsets, timing.
// Assumes a 25 MHz core clock; included by bare name.
`ifndef DCN_CONSTS_SVH
`define DCN_CONSTS_SVH
`define DCN_CLK_MHZ         25
`define DCN_BREAK_US        150
`define DCN_BREAK_CYC       (`DCN_BREAK_US * `DCN_CLK_MHZ)
`define DCN_GAP_BITS        17
`define DCN_HDR_KIND_BIT    7
`define DCN_HDR_RD_BIT      6
`define DCN_HDR_BCAST_BIT   5
`define DCN_HDR_SPECIAL_BIT 4
`define DCN_BCAST_ID        8'hff
`define DCN_BURST_NIBBLE    4'he
`define DCN_SP_PWM_SYNC     5'h1c
`define DCN_SP_REG_RESET    5'h1e
`define DCN_SP_PWM_LATCH    5'h18
`define DCN_FUNC_LAST       8'h1d
`define DCN_NAD_REG         8'h3d
`define DCN_NAD_WR_HDR      8'h80
`define DCN_LAA_HDR         8'ha1
`define DCN_LAA_REG         8'hac
`define DCN_LAA_CNAD        8'h7f
`define DCN_LAA_START       8'h01
`define DCN_LAA_END         8'h03
`define DCN_CRC_INIT        16'h0000
`define DCN_CRC_POLY_REV    16'ha001
`endif

/* rtl/dcn_crc16.sv */
// Byte-wide CRC-16-IBM engine, reflected form.
// Assumes one step per byte from the node on the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "dcn_consts.svh"
module dcn_crc16
	import dcn_pkg::*;
(
	input  wire logic mclk_in,
	input  wire logic rst_in,
	dcn_crc_if.engine crc_if
);
	logic [15:0] crc_ff;

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ((r >> 1) ^ `DCN_CRC_POLY_REV) : (r >> 1);
		return r;
	endfunction : crc_byte

	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
			crc_ff <= `DCN_CRC_INIT;
		// A step with clear starts a new check at that byte, so frames may follow back to back.
		else if (crc_if.step)
			crc_ff <= crc_byte(crc_if.clear ? `DCN_CRC_INIT : crc_ff, crc_if.data);
		else if (crc_if.clear)
			crc_ff <= `DCN_CRC_INIT;
	end

	assign crc_if.crc = crc_ff;
endmodule : dcn_crc16
`default_nettype wire

/* rtl/dcn_crc_if.sv */
// Interface carrying byte updates between the node and its CRC engine.
// Assumes both ends share mclk_in.
`timescale 1ns/1ns
`default_nettype none
interface dcn_crc_if;
	logic        clear;
	logic        step;
	logic [7:0]  data;
	logic [15:0] crc;
	modport engine (input clear, input step, input data, output crc);
	modport user   (output clear, output step, output data, input crc);
endinterface : dcn_crc_if
`default_nettype wire

/* rtl/dcn_node.sv */
// Frame interpreter of one daisy-chain node: break detection, decode, replies, addressing.
// Assumes a byte-level UART outside; rx line comes from a pin and is synchronised here.
`timescale 1ns/1ns
`default_nettype none
`include "dcn_consts.svh"
module dcn_node
	import dcn_pkg::*;
#(
	parameter int BREAK_CYC = `DCN_BREAK_CYC,
	parameter int BIT_CYC   = 25
)
(
	input  wire logic       mclk_in,
	input  wire logic       rst_in,
	input  wire logic       rx_line_in,
	input  wire logic       rx_valid_in,
	input  wire logic [7:0] rx_byte_in,
	input  wire logic       tx_ready_in,
	input  wire logic [7:0] rd_data_in,
	output logic            tx_valid_out,
	output logic [7:0]      tx_byte_out,
	output logic            tx_dir_up_out,
	output logic            wr_strobe_out,
	output logic [7:0]      reg_addr_out,
	output logic [7:0]      wr_data_out,
	output logic            pwm_sync_out,
	output logic            reg_reset_out,
	output logic            pwm_latch_out,
	output logic            wake_out,
	output logic            bus_reset_out,
	output logic            laa_switch_open_out,
	output logic            laa_active_out,
	output logic [7:0]      current_node_address_out,
	output logic            crc_error_out
);
	localparam int GAP_CYC = `DCN_GAP_BITS * BIT_CYC + BIT_CYC;

	dcn_crc_if crc_if ();
	dcn_crc16 u_crc (.mclk_in(mclk_in), .rst_in(rst_in), .crc_if(crc_if));

	dcn_state_t  state_ff;
	logic        rx_s1_ff;
	logic        rx_s2_ff;
	logic [23:0] low_cnt_ff;
	logic        brk_ff;
	logic [7:0]  buf_ff [0:20];
	logic [4:0]  idx_ff;
	logic [4:0]  need_ff;
	logic [4:0]  tx_idx_ff;
	logic [4:0]  tx_len_ff;
	logic [15:0] rx_crc_ff;
	logic [15:0] gap_ff;
	logic        assigned_ff;

	function automatic logic [7:0] rev8(input logic [7:0] b);
		for (int i = 0; i < 8; i++)
			rev8[i] = b[7 - i];
	endfunction : rev8

	function automatic logic [4:0] frame_len(input logic [7:0] h);
		if (!h[`DCN_HDR_KIND_BIT])
			frame_len = 5'd0;
		else if (h[`DCN_HDR_SPECIAL_BIT] && h[7:4] != `DCN_BURST_NIBBLE)
			frame_len = 5'd2;
		else if (h[`DCN_HDR_RD_BIT])
			frame_len = 5'd3;
		else
			frame_len = 5'd4 + {1'b0, h[3:0]};
	endfunction : frame_len

	// The line filter only looks at the second sync stage.
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rx_s1_ff <= 1'b1;
			rx_s2_ff <= 1'b1;
		end
		else
		begin
			rx_s1_ff <= rx_line_in;
			rx_s2_ff <= rx_s1_ff;
		end
	end

	// One detector serves wake and bus reset; both are the same long break.
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			low_cnt_ff <= 24'h000000;
			brk_ff     <= 1'b0;
		end
		else if (rx_s2_ff)
		begin
			low_cnt_ff <= 24'h000000;
			brk_ff     <= 1'b0;
		end
		else if (low_cnt_ff == 24'(BREAK_CYC - 1))
			brk_ff <= 1'b1;
		else
			low_cnt_ff <= low_cnt_ff + 24'h000001;
	end

	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			wake_out      <= 1'b0;
			bus_reset_out <= 1'b0;
		end
		else
		begin
			wake_out      <= brk_ff && !bus_reset_out;
			bus_reset_out <= brk_ff;
		end
	end

	wire logic [7:0] hdr      = buf_ff[0];
	wire logic [7:0] fid      = buf_ff[1];
	wire logic       is_bcast = hdr[`DCN_HDR_BCAST_BIT] && fid == `DCN_BCAST_ID;
	wire logic       is_mine  = fid == current_node_address_out;
	wire logic       is_burst = hdr[7:4] == `DCN_BURST_NIBBLE;
	wire logic       is_spec  = hdr[`DCN_HDR_SPECIAL_BIT] && !is_burst;
	wire logic       is_read  = hdr[`DCN_HDR_RD_BIT] && !is_spec;
	wire logic       crc_ok   = crc_if.crc == rx_crc_ff;
	wire logic       acts     = crc_ok && (is_bcast || is_mine);
	wire logic       is_laa   = hdr == `DCN_LAA_HDR && buf_ff[2] == `DCN_LAA_REG
		&& buf_ff[3] == `DCN_LAA_CNAD && is_bcast;
	wire logic       is_asgn  = hdr == `DCN_NAD_WR_HDR && buf_ff[2] == `DCN_NAD_REG;
	wire logic [4:0] rd_cnt   = {1'b0, hdr[3:0]} + 5'd1;
	wire logic [4:0] tx_total = rd_cnt + 5'd4;

	always_comb
	begin
		crc_if.clear = state_ff == DCN_IDLE || state_ff == DCN_WAIT;
		crc_if.step  = 1'b0;
		crc_if.data  = rx_byte_in;
		if (state_ff == DCN_IDLE)
			crc_if.step = rx_valid_in && rx_byte_in[`DCN_HDR_KIND_BIT];
		else if (state_ff == DCN_RECV)
			crc_if.step = rx_valid_in && idx_ff < need_ff;
		else if (state_ff == DCN_GAP)
		begin
			crc_if.data = {4'h0, hdr[3:0]};
			crc_if.step = 1'b1;
		end
		else if (state_ff == DCN_SEND)
		begin
			// Bytes are stepped as they are loaded, so the check is whole by the low check byte.
			crc_if.data = (tx_idx_ff == 5'd0) ? current_node_address_out : rd_data_in;
			crc_if.step = tx_valid_out && tx_ready_in && tx_idx_ff <= tx_len_ff;
		end
	end

	// Frame reception and state sequencing.
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_ff  <= DCN_IDLE;
			idx_ff    <= 5'd0;
			need_ff   <= 5'd0;
			rx_crc_ff <= 16'h0000;
			gap_ff    <= 16'h0000;
		end
		else if (bus_reset_out)
			state_ff <= DCN_IDLE;
		else
		begin
			unique case (state_ff)
				DCN_IDLE:
					if (rx_valid_in && rx_byte_in[`DCN_HDR_KIND_BIT])
					begin
						buf_ff[0] <= rx_byte_in;
						idx_ff    <= 5'd1;
						need_ff   <= frame_len(rx_byte_in);
						state_ff  <= DCN_RECV;
					end
				DCN_RECV:
					if (rx_valid_in)
					begin
						if (idx_ff < need_ff)
							buf_ff[idx_ff] <= rx_byte_in;
						else if (idx_ff == need_ff)
							rx_crc_ff[7:0] <= rx_byte_in;
						else
						begin
							rx_crc_ff[15:8] <= rx_byte_in;
							state_ff        <= DCN_CHECK;
						end
						idx_ff <= idx_ff + 5'd1;
					end
				DCN_CHECK:
				begin
					if (acts && is_read && is_bcast && is_burst)
						gap_ff <= 16'(GAP_CYC);
					else
						gap_ff <= 16'(GAP_CYC);
					state_ff <= (acts && is_read) ? DCN_WAIT : DCN_IDLE;
				end
				DCN_WAIT:
					// Every read waits the same GAP_CYC, broadcast burst or not.
					if (gap_ff != 16'h0000)
						gap_ff <= gap_ff - 16'h0001;
					else
						state_ff <= DCN_GAP;
				DCN_GAP:
					state_ff <= DCN_SEND;
				DCN_SEND:
					if (tx_valid_out && tx_ready_in && tx_idx_ff == tx_total - 5'd1)
						state_ff <= DCN_IDLE;
			endcase
		end
	end

	// Reply sequencing: header, address, data bytes, then check bytes, loaded on each accept.
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			tx_valid_out  <= 1'b0;
			tx_byte_out   <= 8'h00;
			tx_dir_up_out <= 1'b0;
			tx_idx_ff     <= 5'd0;
			tx_len_ff     <= 5'd0;
			reg_addr_out  <= 8'h00;
		end
		else if (state_ff == DCN_GAP)
		begin
			tx_dir_up_out <= 1'b1;
			tx_valid_out  <= 1'b1;
			tx_byte_out   <= {4'h0, hdr[3:0]};
			tx_idx_ff     <= 5'd0;
			tx_len_ff     <= rd_cnt;
			reg_addr_out  <= buf_ff[2];
		end
		else if (state_ff == DCN_SEND && tx_valid_out && tx_ready_in)
		begin
			tx_idx_ff <= tx_idx_ff + 5'd1;
			if (tx_idx_ff == tx_total - 5'd1)
			begin
				tx_valid_out  <= 1'b0;
				tx_dir_up_out <= 1'b0;
			end
			else if (tx_idx_ff == 5'd0)
				tx_byte_out <= current_node_address_out;
			else if (tx_idx_ff <= tx_len_ff)
			begin
				tx_byte_out <= rd_data_in;
				if (tx_idx_ff != tx_len_ff)
					reg_addr_out <= reg_addr_out + 8'h01;
			end
			else if (tx_idx_ff == tx_len_ff + 5'd1)
				tx_byte_out <= rev8(crc_if.crc[7:0]);
			else
				tx_byte_out <= rev8(crc_if.crc[15:8]);
		end
		else if (state_ff == DCN_CHECK)
			reg_addr_out <= buf_ff[2];
	end

	// Register writes and special command pulses.
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			wr_strobe_out <= 1'b0;
			wr_data_out   <= 8'h00;
			pwm_sync_out  <= 1'b0;
			reg_reset_out <= 1'b0;
			pwm_latch_out <= 1'b0;
			crc_error_out <= 1'b0;
		end
		else
		begin
			wr_strobe_out <= 1'b0;
			pwm_sync_out  <= 1'b0;
			reg_reset_out <= 1'b0;
			pwm_latch_out <= 1'b0;
			crc_error_out <= state_ff == DCN_CHECK && !crc_ok;
			if (state_ff == DCN_CHECK && acts)
			begin
				if (is_spec)
				begin
					pwm_sync_out  <= hdr[4:0] == `DCN_SP_PWM_SYNC && is_bcast;
					reg_reset_out <= hdr[4:0] == `DCN_SP_REG_RESET;
					pwm_latch_out <= hdr[4:0] == `DCN_SP_PWM_LATCH;
				end
				else if (!is_read && !is_laa && !is_asgn)
				begin
					// Only the first data byte is strobed; later bytes of multi-byte writes are not output.
					wr_strobe_out <= 1'b1;
					wr_data_out   <= buf_ff[3];
				end
			end
		end
	end

	// Location-based address assignment.
	always_ff @(posedge mclk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			current_node_address_out <= 8'h00;
			laa_switch_open_out      <= 1'b0;
			laa_active_out           <= 1'b0;
			assigned_ff              <= 1'b0;
		end
		else if (state_ff == DCN_CHECK && crc_ok)
		begin
			if (is_laa && buf_ff[4] == `DCN_LAA_START)
			begin
				current_node_address_out <= 8'h00;
				laa_switch_open_out      <= 1'b1;
				laa_active_out           <= 1'b1;
				assigned_ff              <= 1'b0;
			end
			else if (is_laa && buf_ff[4] == `DCN_LAA_END)
			begin
				laa_active_out      <= 1'b0;
				laa_switch_open_out <= 1'b0;
			end
			else if (is_asgn && is_mine && laa_active_out && !assigned_ff)
			begin
				current_node_address_out <= buf_ff[3];
				laa_switch_open_out      <= 1'b0;
				assigned_ff              <= 1'b1;
			end
		end
	end
endmodule : dcn_node
`default_nettype wire

/* rtl/dcn_pkg.sv */
// Types shared by the frame node modules.
// Assumes dcn_consts.svh is available on the include path.
package dcn_pkg;
	typedef enum logic [5:0] {
		DCN_IDLE  = 6'h01,
		DCN_RECV  = 6'h02,
		DCN_CHECK = 6'h04,
		DCN_GAP   = 6'h08,
		DCN_SEND  = 6'h10,
		DCN_WAIT  = 6'h20
	} dcn_state_t;
endpackage : dcn_pkg

/* tb/dcn_host_model.sv */
// Host side model: accepts reply bytes and serves register reads.
// Assumes the node offers bytes on a valid and ready pair.
`timescale 1ns/1ns
`default_nettype none
module dcn_host_model (
	input  wire logic       mclk_in,
	input  wire logic       rst_in,
	input  wire logic       slow_in,
	input  wire logic       tx_valid_in,
	input  wire logic [7:0] tx_byte_in,
	input  wire logic [7:0] reg_addr_in,
	output logic            tx_ready_out,
	output logic [7:0]      rd_data_out
);
	logic [7:0] got_q[$];
	// Register contents are a pattern of the address, so reads need no storage.
	assign rd_data_out = reg_addr_in ^ 8'h5a;
	always @(posedge mclk_in)
	begin
		if (!rst_in && tx_valid_in && tx_ready_out)
			got_q.push_back(tx_byte_in);
		tx_ready_out <= rst_in ? 1'b0 : (slow_in ? !tx_ready_out : 1'b1);
	end
endmodule : dcn_host_model
`default_nettype wire

/* tb/dcn_node_monitor.sv */
// Concurrent checks on the frame node ports.
// Assumes it is bound to every dcn_node instance.
`timescale 1ns/1ns
`default_nettype none
module dcn_node_monitor (
	input wire logic       mclk_in,
	input wire logic       rst_in,
	input wire logic       rx_line_in,
	input wire logic       rx_valid_in,
	input wire logic       tx_ready_in,
	input wire logic       tx_valid_out,
	input wire logic [7:0] tx_byte_out,
	input wire logic       tx_dir_up_out,
	input wire logic       wr_strobe_out,
	input wire logic       crc_error_out,
	input wire logic       wake_out,
	input wire logic       bus_reset_out,
	input wire logic       laa_switch_open_out,
	input wire logic       laa_active_out,
	input wire logic [7:0] current_node_address_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	sequence held_s;
		tx_valid_out && !tx_ready_in;
	endsequence
	sequence same_s;
		tx_valid_out && $stable(tx_byte_out);
	endsequence
	hold_byte_a: assert property (held_s |=> same_s)
		else $error("Reply byte moved before accept.");
	reply_hdr_a: assert property ($rose(tx_valid_out) |-> !tx_byte_out[7])
		else $error("Reply header bit 7 set.");
	dir_up_a: assert property (tx_valid_out |-> tx_dir_up_out)
		else $error("Reply without upstream drive.");
	bad_check_a: assert property (crc_error_out |-> (!wr_strobe_out && !tx_valid_out)[*4])
		else $error("Action after bad check.");
	wr_cause_a: assert property (wr_strobe_out |-> $past(rx_valid_in, 2) || $past(rx_valid_in, 3))
		else $error("Write without received frame.");
	switch_only_a: assert property (laa_switch_open_out |-> laa_active_out)
		else $error("Switch open outside assignment.");
	start_clear_a: assert property ($rose(laa_active_out) |-> laa_switch_open_out && current_node_address_out == 8'h00)
		else $error("Start did not clear address.");
	adopt_close_a: assert property ($fell(laa_switch_open_out) && laa_active_out |-> current_node_address_out != 8'h00)
		else $error("Switch closed without address.");
	keep_addr_a: assert property (laa_active_out && !laa_switch_open_out |=> $stable(current_node_address_out) || laa_switch_open_out)
		else $error("Assigned node took a new address.");
	break_len_a: assert property ($rose(bus_reset_out) |-> !$past(rx_line_in, 3) && !$past(rx_line_in, 8))
		else $error("Bus reset without long break.");
	wake_len_a: assert property (wake_out |-> !$past(rx_line_in, 3))
		else $error("Wake without break low.");
endmodule : dcn_node_monitor
bind dcn_node dcn_node_monitor u_dcn_node_monitor (.mclk_in, .rst_in, .rx_line_in, .rx_valid_in,
	.tx_ready_in, .tx_valid_out, .tx_byte_out, .tx_dir_up_out, .wr_strobe_out, .crc_error_out,
	.wake_out, .bus_reset_out, .laa_switch_open_out, .laa_active_out, .current_node_address_out);
`default_nettype wire

/* tb/dcn_node_tb_top.sv */
// Self-checking bench for the frame node.
// Assumes short break and bit counts so the run stays brief.
`timescale 1ns/1ns
`default_nettype none
module dcn_node_tb_top;
	logic       mclk_in = 0, rst_in = 1, rx_line_in = 1, rx_valid_in = 0, slow = 0;
	logic [7:0] rx_byte_in = 8'h00, rd_data_in, tx_byte_out, reg_addr_out, wr_data_out, cna;
	logic       tx_ready_in, tx_valid_out, tx_dir_up_out, wr_strobe_out, pwm_sync_out;
	logic       reg_reset_out, pwm_latch_out, wake_out, bus_reset_out, sw_open, active;
	logic       crc_error_out, brk = 0;
	logic [7:0] wa, wd;
	int         failures = 0, n_checks = 0, cyc = 0, n_wr, n_sy, n_rs, n_la, n_er, n_wk;
	dcn_node #(.BREAK_CYC(20), .BIT_CYC(2)) u_dcn_node (.mclk_in, .rst_in, .rx_line_in,
		.rx_valid_in, .rx_byte_in, .tx_ready_in, .rd_data_in, .tx_valid_out, .tx_byte_out,
		.tx_dir_up_out, .wr_strobe_out, .reg_addr_out, .wr_data_out, .pwm_sync_out,
		.reg_reset_out, .pwm_latch_out, .wake_out, .bus_reset_out,
		.laa_switch_open_out(sw_open), .laa_active_out(active),
		.current_node_address_out(cna), .crc_error_out);
	dcn_host_model u_dcn_host_model (.mclk_in, .rst_in, .slow_in(slow), .tx_valid_in(tx_valid_out),
		.tx_byte_in(tx_byte_out), .reg_addr_in(reg_addr_out), .tx_ready_out(tx_ready_in),
		.rd_data_out(rd_data_in));
	initial
	begin
		forever #20 mclk_in = ~mclk_in;
	end
	always @(posedge mclk_in)
	begin
		cyc++;
		if (wr_strobe_out === 1'b1)
		begin
			n_wr++;
			wa = reg_addr_out;
			wd = wr_data_out;
		end
		n_sy += (pwm_sync_out === 1'b1);
		n_rs += (reg_reset_out === 1'b1);
		n_la += (pwm_latch_out === 1'b1);
		n_er += (crc_error_out === 1'b1);
		n_wk += (wake_out === 1'b1);
		brk |= (bus_reset_out === 1'b1);
		if (cyc == 12000)
		begin
			failures++;
			final_report();
		end
	end
	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'h0000;
		foreach (q[i])
		begin
			c = c ^ {8'h00, q[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return c;
	endfunction : crc16
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e)
		begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic send(input logic [7:0] q[$], input logic bad = 0);
		logic [15:0] c;
		c = crc16(q) ^ {15'h0000, bad};
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		n_wr = 0; n_sy = 0; n_rs = 0; n_la = 0; n_er = 0;
		foreach (q[i])
		begin
			@(posedge mclk_in);
			rx_valid_in <= 1'b1;
			rx_byte_in  <= q[i];
		end
		@(posedge mclk_in);
		rx_valid_in <= 1'b0;
		repeat (6) @(posedge mclk_in);
	endtask : send
	// A long low on the line also resynchronises framing after stray bytes.
	task automatic bus_break;
		@(posedge mclk_in);
		rx_line_in <= 1'b0;
		repeat (30) @(posedge mclk_in);
		rx_line_in <= 1'b1;
		repeat (6) @(posedge mclk_in);
	endtask : bus_break
	task automatic t_break;
		chk("addr_rst", 8'h00, cna);
		chk("switch_rst", 1'b0, sw_open);
		bus_break();
		chk("wake", 1, n_wk);
		chk("bus_reset", 1'b1, brk);
		chk("bus_reset_end", 1'b0, bus_reset_out);
		$display("test break done");
	endtask : t_break
	task automatic t_laa;
		send('{8'ha1, 8'hff, 8'hac, 8'h7f, 8'h01});
		chk("open", 1'b1, sw_open);
		chk("cleared", 8'h00, cna);
		send('{8'h80, 8'h00, 8'h3d, 8'h05});
		chk("adopt", 8'h05, cna);
		chk("closed", 1'b0, sw_open);
		send('{8'h80, 8'h05, 8'h3d, 8'h07});
		chk("ignore", 8'h05, cna);
		send('{8'ha1, 8'hff, 8'hac, 8'h7f, 8'h03});
		chk("finished", 1'b0, active);
		$display("test laa done");
	endtask : t_laa
	task automatic t_write;
		send('{8'h80, 8'h05, 8'h10, 8'haa});
		chk("wr_n", 1, n_wr);
		chk("wr_addr", 8'h10, wa);
		chk("wr_data", 8'haa, wd);
		send('{8'h80, 8'h05, 8'h10, 8'haa}, 1);
		chk("bad_wr", 0, n_wr);
		chk("bad_flag", 1, n_er);
		send('{8'h80, 8'h06, 8'h10, 8'haa});
		chk("other_id", 0, n_wr);
		send('{8'h00, 8'h05, 8'h10, 8'haa});
		chk("reply_kind", 0, n_wr);
		bus_break();
		send('{8'ha0, 8'hff, 8'h11, 8'hbb});
		chk("bcast_addr", 8'h11, wa);
		chk("bcast_data", 8'hbb, wd);
		$display("test write done");
	endtask : t_write
	task automatic t_special;
		logic [7:0] hd[5] = '{8'hbc, 8'h9e, 8'hbe, 8'h98, 8'h9c};
		logic [7:0] id[5] = '{8'hff, 8'h05, 8'hff, 8'h05, 8'h05};
		for (int i = 0; i < 5; i++)
		begin
			send('{hd[i], id[i]});
			chk("sync", i == 0, n_sy);
			chk("regs_reset", i == 1 || i == 2, n_rs);
			chk("latch", i == 3, n_la);
		end
		$display("test special done");
	endtask : t_special
	task automatic rd(input logic [7:0] hdr, input logic [7:0] a, input int n, input logic s);
		logic [7:0] e[$];
		logic [15:0] c;
		slow <= s;
		u_dcn_host_model.got_q.delete();
		send('{hdr, 8'h05, a});
		for (int w = 0; w < 600 && u_dcn_host_model.got_q.size() < n + 4; w++)
			@(posedge mclk_in);
		e = '{8'(n - 1), 8'h05};
		for (int i = 0; i < n; i++)
			e.push_back(8'(a + i) ^ 8'h5a);
		c = crc16(e);
		e.push_back({<<{c[7:0]}});
		e.push_back({<<{c[15:8]}});
		chk("reply_len", n + 4, u_dcn_host_model.got_q.size());
		foreach (e[i])
			chk("reply_byte", e[i], u_dcn_host_model.got_q[i]);
	endtask : rd
	task automatic t_read;
		rd(8'hc0, 8'h3d, 1, 0);
		rd(8'he3, 8'h10, 4, 1);
		rd(8'hcf, 8'h20, 16, 0);
		$display("test read done");
	endtask : t_read
	task final_report;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	initial
	begin
		repeat (6) @(posedge mclk_in);
		rst_in <= 1'b0;
		n_wk = 0;
		@(posedge mclk_in);
		t_break();
		t_laa();
		t_write();
		t_special();
		t_read();
		final_report();
	end
endmodule : dcn_node_tb_top
`default_nettype wire
